// ===== src/slbf_pkg.sv
package slbf_pkg;
   // ****************************************************
   // register map (byte addresses)
   // ****************************************************
   localparam logic [7:0] ADDR_BIAS_SPEED   = 8'h00;
   localparam logic [7:0] ADDR_BIAS_BAND    = 8'h04;
   localparam logic [7:0] ADDR_FF_GAIN      = 8'h08;
   localparam logic [7:0] ADDR_FF_FILTER    = 8'h0c;
   localparam logic [7:0] ADDR_OPT_SELECT   = 8'h10;
   localparam logic [7:0] ADDR_POS_GAIN     = 8'h14;
   localparam logic [7:0] ADDR_SPEED_GAIN   = 8'h18;
   localparam logic [7:0] ADDR_SPEED_INT    = 8'h1c;
   localparam logic [7:0] ADDR_INERTIA      = 8'h20;
   localparam logic [7:0] ADDR_TORQUE_FILT  = 8'h24;
   localparam logic [7:0] ADDR_POS_DEV      = 8'h28;
   localparam logic [7:0] ADDR_SPEED_CMD    = 8'h2c;
   localparam logic [7:0] ADDR_CURRENT_CMD  = 8'h30;
   // ****************************************************
   // setting limits and reset values
   // ****************************************************
   localparam logic [15:0] BIAS_SPEED_MAX   = 16'h01c2;  // 450 r/min
   localparam logic [15:0] BIAS_BAND_MAX    = 16'h00fa;  // 250 command units
   localparam logic [15:0] FF_GAIN_MAX      = 16'h0064;  // 100 %
   localparam logic [15:0] FF_FILTER_MAX    = 16'h000f;  // shift of filter
   localparam logic [3:0]  OPT_SEL_TORQUE_FF = 4'h2;
   localparam logic [15:0] RST_BIAS_SPEED   = 16'h0000;
   localparam logic [15:0] RST_BIAS_BAND    = 16'h0007;
   localparam logic [15:0] RST_FF_GAIN      = 16'h0000;
   localparam logic [15:0] RST_FF_FILTER    = 16'h0000;
   localparam logic [3:0]  RST_OPT_SELECT   = 4'h0;
   localparam logic [15:0] RST_POS_GAIN     = 16'h0028;
   localparam logic [15:0] RST_SPEED_GAIN   = 16'h0028;
   localparam logic [15:0] RST_SPEED_INT    = 16'h0000;
   localparam logic [15:0] RST_INERTIA      = 16'h0000;
   localparam logic [15:0] RST_TORQUE_FILT  = 16'h0000;
   localparam int          GAIN_SHIFT       = 6;
   localparam int          PCT_SHIFT        = 7;
   typedef enum logic [1:0] {SLBF_IDLE, SLBF_WRITE, SLBF_READ} slbf_phase_t;
endpackage : slbf_pkg

// ===== src/slbf_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - the position loop output is the speed loop command and the speed loop output is the current loop command.
// - while the deviation magnitude exceeds the bias band, the bias speed is added to the speed command with the sign of the deviation.
// - once the deviation magnitude is within the bias band, no bias speed is added.
// - the bias speed setting takes 0 to 450 r/min and larger writes are clamped.
// - the bias band setting takes 0 to 250 command units and larger writes are clamped.
// - the difference of successive position commands is added to the speed loop input as feed-forward.
// - the feed-forward gain takes 0 to 100 percent and scales the feed-forward term.
// - with option select equal to 2 the host option value is used as torque feed-forward.
// - the torque feed-forward value is added directly to the current loop input.
module slbf_top (
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // motion inputs, sampled on sample_strobe
   input  wire logic        sample_strobe,
   input  wire logic [31:0] position_command,
   input  wire logic [31:0] position_feedback,
   input  wire logic [31:0] speed_feedback,
   input  wire logic [15:0] option_command_value,
   // loop outputs
   output logic      [31:0] speed_command,
   output logic      [31:0] current_command
);
   import slbf_pkg::*;

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
      clamp16 = (v > {16'h0000, lim}) ? lim : v[15:0];
   endfunction : clamp16

   function automatic logic signed [31:0] sat_add(input logic signed [31:0] a, input logic signed [31:0] b);
      logic signed [32:0] s;
      s = {a[31], a} + {b[31], b};
      if (s[32] != s[31])
         sat_add = s[32] ? 32'sh80000000 : 32'sh7fffffff;
      else
         sat_add = s[31:0];
   endfunction : sat_add

   // ****************************************************
   // bus slave
   // ****************************************************
   logic [15:0] bias_speed_setting_reg;
   logic [15:0] bias_band_setting_reg;
   logic [15:0] feedforward_gain_setting_reg;
   logic [15:0] feedforward_filter_setting_reg;
   logic [3:0]  option_command_select_reg;
   logic [15:0] position_loop_gain_setting_reg;
   logic [15:0] speed_loop_gain_setting_reg;
   logic [15:0] speed_integral_time_setting_reg;
   logic [15:0] inertia_ratio_setting_reg;
   logic [15:0] torque_filter_time_setting_reg;
   logic [7:0]  addr_reg;
   slbf_phase_t phase_reg;
   logic signed [31:0] deviation_reg;

   wire         bus_take   = hsel & hready & htrans[1];
   wire         wr_phase   = (phase_reg == SLBF_WRITE);
   wire         wr_bias_sp = wr_phase & (addr_reg == ADDR_BIAS_SPEED);
   wire         wr_bias_bd = wr_phase & (addr_reg == ADDR_BIAS_BAND);
   wire         wr_ff_gain = wr_phase & (addr_reg == ADDR_FF_GAIN);
   wire         wr_ff_filt = wr_phase & (addr_reg == ADDR_FF_FILTER);
   wire         wr_opt_sel = wr_phase & (addr_reg == ADDR_OPT_SELECT);
   wire         wr_pos_g   = wr_phase & (addr_reg == ADDR_POS_GAIN);
   wire         wr_spd_g   = wr_phase & (addr_reg == ADDR_SPEED_GAIN);
   wire         wr_spd_i   = wr_phase & (addr_reg == ADDR_SPEED_INT);
   wire         wr_inert   = wr_phase & (addr_reg == ADDR_INERTIA);
   wire         wr_tq_filt = wr_phase & (addr_reg == ADDR_TORQUE_FILT);
   wire [31:0]  rd_mux =
      (haddr[7:0] == ADDR_BIAS_SPEED)  ? {16'h0000, bias_speed_setting_reg} :
      (haddr[7:0] == ADDR_BIAS_BAND)   ? {16'h0000, bias_band_setting_reg} :
      (haddr[7:0] == ADDR_FF_GAIN)     ? {16'h0000, feedforward_gain_setting_reg} :
      (haddr[7:0] == ADDR_FF_FILTER)   ? {16'h0000, feedforward_filter_setting_reg} :
      (haddr[7:0] == ADDR_OPT_SELECT)  ? {28'h0000000, option_command_select_reg} :
      (haddr[7:0] == ADDR_POS_GAIN)    ? {16'h0000, position_loop_gain_setting_reg} :
      (haddr[7:0] == ADDR_SPEED_GAIN)  ? {16'h0000, speed_loop_gain_setting_reg} :
      (haddr[7:0] == ADDR_SPEED_INT)   ? {16'h0000, speed_integral_time_setting_reg} :
      (haddr[7:0] == ADDR_INERTIA)     ? {16'h0000, inertia_ratio_setting_reg} :
      (haddr[7:0] == ADDR_TORQUE_FILT) ? {16'h0000, torque_filter_time_setting_reg} :
      (haddr[7:0] == ADDR_POS_DEV)     ? deviation_reg :
      (haddr[7:0] == ADDR_SPEED_CMD)   ? speed_command :
      (haddr[7:0] == ADDR_CURRENT_CMD) ? current_command : 32'h00000000;

   // read data is captured at the address phase so the data phase takes no wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= SLBF_IDLE;
      end else if (hready) begin
         phase_reg <= !bus_take ? SLBF_IDLE : (hwrite ? SLBF_WRITE : SLBF_READ);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg <= 8'h00;
      end else if (hready) begin
         addr_reg <= haddr[7:0];
      end
   end

   // a read overlapping the data phase of a write to the same register returns the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (bus_take & !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   // ****************************************************
   // bus response
   // ****************************************************
   // the slave never stretches a transfer and never reports an error
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ****************************************************
   // setting registers
   // ****************************************************
   // writes above the range of bias speed, bias band, ff gain or ff filter are clamped rather than wrapped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bias_speed_setting_reg <= RST_BIAS_SPEED;
      end else if (wr_bias_sp) begin
         bias_speed_setting_reg <= clamp16(hwdata, BIAS_SPEED_MAX);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bias_band_setting_reg <= RST_BIAS_BAND;
      end else if (wr_bias_bd) begin
         bias_band_setting_reg <= clamp16(hwdata, BIAS_BAND_MAX);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         feedforward_gain_setting_reg <= RST_FF_GAIN;
      end else if (wr_ff_gain) begin
         feedforward_gain_setting_reg <= clamp16(hwdata, FF_GAIN_MAX);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         feedforward_filter_setting_reg <= RST_FF_FILTER;
      end else if (wr_ff_filt) begin
         feedforward_filter_setting_reg <= clamp16(hwdata, FF_FILTER_MAX);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         option_command_select_reg <= RST_OPT_SELECT;
      end else if (wr_opt_sel) begin
         option_command_select_reg <= hwdata[3:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         position_loop_gain_setting_reg <= RST_POS_GAIN;
      end else if (wr_pos_g) begin
         position_loop_gain_setting_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed_loop_gain_setting_reg <= RST_SPEED_GAIN;
      end else if (wr_spd_g) begin
         speed_loop_gain_setting_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed_integral_time_setting_reg <= RST_SPEED_INT;
      end else if (wr_spd_i) begin
         speed_integral_time_setting_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inertia_ratio_setting_reg <= RST_INERTIA;
      end else if (wr_inert) begin
         inertia_ratio_setting_reg <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         torque_filter_time_setting_reg <= RST_TORQUE_FILT;
      end else if (wr_tq_filt) begin
         torque_filter_time_setting_reg <= hwdata[15:0];
      end
   end

   // ****************************************************
   // loop arithmetic
   // ****************************************************
   // position and speed loop gains are plain fixed-point multipliers; integral, inertia and torque filter are held for software only
   logic signed [31:0] prev_cmd_reg;
   logic signed [31:0] ff_filt_reg;

   wire signed [31:0] dev_next   = $signed(position_command) - $signed(position_feedback);
   wire        [31:0] dev_mag    = deviation_reg[31] ? 32'(-deviation_reg) : 32'(deviation_reg);
   wire               bias_on    = dev_mag > {16'h0000, bias_band_setting_reg};
   wire signed [31:0] bias_term  = !bias_on ? 32'sd0 :
                                   deviation_reg[31] ? -$signed({16'h0000, bias_speed_setting_reg})
                                                     : $signed({16'h0000, bias_speed_setting_reg});
   wire signed [31:0] cmd_diff   = $signed(position_command) - prev_cmd_reg;
   wire signed [47:0] ff_prod    = cmd_diff * $signed({1'b0, feedforward_gain_setting_reg});
   // the gain is a percentage: full scale passes the command difference unchanged
   wire signed [31:0] ff_scaled  = 32'(ff_prod / $signed(48'(FF_GAIN_MAX)));
   wire signed [31:0] ff_step    = (ff_scaled - ff_filt_reg) >>> feedforward_filter_setting_reg[3:0];
   wire signed [47:0] pos_prod   = deviation_reg * $signed({1'b0, position_loop_gain_setting_reg});
   wire signed [31:0] pos_out    = 32'(pos_prod >>> GAIN_SHIFT);
   wire signed [31:0] spd_next   = sat_add(sat_add(pos_out, bias_term), ff_filt_reg);
   wire signed [31:0] spd_err    = sat_add(speed_command, -$signed(speed_feedback));
   wire signed [47:0] spd_prod   = spd_err * $signed({1'b0, speed_loop_gain_setting_reg});
   wire signed [31:0] spd_out    = 32'(spd_prod >>> GAIN_SHIFT);
   wire               tq_ff_sel  = (option_command_select_reg == OPT_SEL_TORQUE_FF);
   wire signed [31:0] tq_ff      = tq_ff_sel ? 32'(signed'(option_command_value)) : 32'sd0;
   wire signed [31:0] cur_next   = sat_add(spd_out, tq_ff);

   // each sample_strobe advances the loops by one control period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deviation_reg <= 32'sd0;
      end else if (sample_strobe) begin
         deviation_reg <= dev_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_cmd_reg <= 32'sd0;
      end else if (sample_strobe) begin
         prev_cmd_reg <= $signed(position_command);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ff_filt_reg <= 32'sd0;
      end else if (sample_strobe) begin
         ff_filt_reg <= ff_filt_reg + ff_step;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed_command <= 32'h00000000;
      end else if (sample_strobe) begin
         speed_command <= spd_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         current_command <= 32'h00000000;
      end else if (sample_strobe) begin
         current_command <= cur_next;
      end
   end
endmodule : slbf_top
`default_nettype wire

// ===== test/servo_loop_bias_feedforward_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module servo_loop_bias_feedforward_tb_top;
   import slbf_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, step_req = 1'b0, accel = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, cmd_in = 32'h0, fb_in = 32'h0, rdata;
   logic [15:0] tff_in = 16'h0;
   wire logic [31:0] hrdata, speed_command, current_command, pc, pf, sf;
   wire logic hreadyout, hresp, strobe;
   wire logic [15:0] ocv;
   int bad_count = 0, num_checks = 0, cycles = 0;
   logic [7:0]  ra [6] = '{ADDR_BIAS_SPEED, ADDR_BIAS_BAND, ADDR_POS_GAIN, ADDR_SPEED_GAIN, ADDR_OPT_SELECT, 8'h34};
   logic [31:0] rv [6] = '{32'(RST_BIAS_SPEED), 32'(RST_BIAS_BAND), 32'(RST_POS_GAIN), 32'(RST_SPEED_GAIN),
                           32'(RST_OPT_SELECT), 32'h0};
   logic [31:0] dv [4] = '{32'd8, 32'd7, -32'sd8, 32'd100};
   logic [31:0] bs [4] = '{32'd450, 32'd450, 32'd450, 32'd0};
   logic [31:0] ex [4] = '{32'd450, 32'd0, -32'sd450, 32'd0};
   always #20 hclk = ~hclk;
   slbf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sample_strobe(strobe), .position_command(pc), .position_feedback(pf), .speed_feedback(sf),
      .option_command_value(ocv), .speed_command(speed_command), .current_command(current_command));
   slbf_host_model HOST (.hclk(hclk), .hresetn(hresetn), .step_req(step_req), .accel(accel), .cmd_in(cmd_in),
      .fb_in(fb_in), .tff_in(tff_in), .sample_strobe(strobe), .position_command(pc), .position_feedback(pf),
      .speed_feedback(sf), .option_command_value(ocv));
   // ****************************************************
   // bus and loop tasks
   // ****************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask : xfer
   task automatic step(input logic [31:0] c, input logic [31:0] f);
      cmd_in <= c;
      fb_in <= f;
      step_req <= 1'b1;
      @(posedge hclk);
      step_req <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask : step
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      foreach (ra[i]) begin
         xfer(1'b0, ra[i], 32'h0);
         chk("reset value", rv[i], rdata);
      end
      $display("test reset_values done");
      xfer(1'b1, ADDR_BIAS_SPEED, 32'h1f4);
      xfer(1'b0, ADDR_BIAS_SPEED, 32'h0);
      chk("bias speed clamp", 32'h1c2, rdata);
      xfer(1'b1, ADDR_BIAS_BAND, 32'h12c);
      xfer(1'b0, ADDR_BIAS_BAND, 32'h0);
      chk("bias band clamp", 32'hfa, rdata);
      xfer(1'b1, ADDR_FF_GAIN, 32'h65);
      xfer(1'b0, ADDR_FF_GAIN, 32'h0);
      chk("ff gain clamp", 32'h64, rdata);
      xfer(1'b1, ADDR_FF_FILTER, 32'h20);
      xfer(1'b0, ADDR_FF_FILTER, 32'h0);
      chk("ff filter clamp", 32'(FF_FILTER_MAX), rdata);
      $display("test clamps done");
      xfer(1'b1, ADDR_BIAS_BAND, 32'h7);
      xfer(1'b1, ADDR_POS_GAIN, 32'h0);
      xfer(1'b1, ADDR_FF_GAIN, 32'h0);
      xfer(1'b1, ADDR_FF_FILTER, 32'h0);
      foreach (dv[i]) begin
         xfer(1'b1, ADDR_BIAS_SPEED, bs[i]);
         step(dv[i], 32'h0);
         step(dv[i], 32'h0);
         chk("speed command", ex[i], speed_command);
         xfer(1'b0, ADDR_POS_DEV, 32'h0);
         chk("deviation", dv[i], rdata);
      end
      $display("test bias done");
      xfer(1'b1, ADDR_FF_GAIN, 32'h64);
      for (int k = 1; k <= 4; k++) step(32'(64 * k), 32'(64 * k));
      chk("ff speed command", 32'd64, speed_command);
      chk("cascade current", 32'd40, current_command);
      xfer(1'b1, ADDR_FF_FILTER, 32'h1);
      xfer(1'b1, ADDR_FF_GAIN, 32'h0);
      step(32'd320, 32'd320);
      step(32'd320, 32'd320);
      chk("ff filtered speed command", 32'd32, speed_command);
      xfer(1'b1, ADDR_FF_FILTER, 32'h0);
      $display("test feedforward done");
      xfer(1'b1, ADDR_FF_GAIN, 32'h0);
      xfer(1'b1, ADDR_SPEED_GAIN, 32'h0);
      xfer(1'b1, ADDR_OPT_SELECT, 32'(OPT_SEL_TORQUE_FF));
      accel <= 1'b1;
      tff_in <= 16'h0064;
      step(32'd256, 32'd256);
      step(32'd256, 32'd256);
      chk("torque ff current", 32'd100, current_command);
      accel <= 1'b0;
      step(32'd256, 32'd256);
      chk("torque ff at constant speed", 32'd0, current_command);
      accel <= 1'b1;
      xfer(1'b1, ADDR_OPT_SELECT, 32'h0);
      step(32'd256, 32'd256);
      step(32'd256, 32'd256);
      chk("no torque ff current", 32'd0, current_command);
      $display("test torque_ff done");
      print_verdict();
   end
endmodule : servo_loop_bias_feedforward_tb_top
bind slbf_top slbf_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hrdata(hrdata), .htrans(htrans),
   .sample_strobe(sample_strobe), .speed_command(speed_command), .current_command(current_command));
`default_nettype wire

// ===== test/slbf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module slbf_host_model (
   input wire logic        hclk, hresetn, step_req, accel,
   input wire logic [31:0] cmd_in, fb_in,
   input wire logic [15:0] tff_in,
   output logic            sample_strobe,
   output logic     [31:0] position_command, position_feedback, speed_feedback,
   output logic     [15:0] option_command_value
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_strobe <= 1'b0;
         position_command <= 32'h0;
         position_feedback <= 32'h0;
         speed_feedback <= 32'h0;
         option_command_value <= 16'h0;
      end else begin
         sample_strobe <= step_req;
         if (step_req) begin
            position_command <= cmd_in;
            position_feedback <= fb_in;
            // torque feed-forward only while the axis changes speed
            option_command_value <= accel ? tff_in : 16'h0000;
         end
      end
   end
endmodule : slbf_host_model
`default_nettype wire

// ===== test/slbf_sva.sv
`timescale 1ns/1ps
`default_nettype none
module slbf_sva
   import slbf_pkg::*;
(
   // bus and clock
   input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [31:0] haddr, hrdata,
   input wire logic [1:0]  htrans,
   // loop path
   input wire logic        sample_strobe,
   input wire logic [31:0] speed_command, current_command
);
   wire logic rd_go = hsel & hready & htrans[1] & ~hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_speed_hold: assert property ($past(hresetn) && !$past(sample_strobe) |-> $stable(speed_command))
      else $error("speed command moved without strobe");
   a_current_hold: assert property ($past(hresetn) && !$past(sample_strobe) |-> $stable(current_command))
      else $error("current command moved without strobe");
   a_unmapped_zero: assert property (rd_go && haddr[7:0] > 8'h30 |=> hrdata == 32'h0) else $error("unmapped read");
   a_band_limit: assert property (rd_go && haddr[7:0] == ADDR_BIAS_BAND |=> hrdata <= 32'h000000fa)
      else $error("bias band over limit");
   a_bias_limit: assert property (rd_go && haddr[7:0] == ADDR_BIAS_SPEED |=> hrdata <= 32'h000001c2)
      else $error("bias speed over limit");
   a_gain_limit: assert property (rd_go && haddr[7:0] == ADDR_FF_GAIN |=> hrdata <= 32'h00000064)
      else $error("ff gain over limit");
   a_filter_limit: assert property (rd_go && haddr[7:0] == ADDR_FF_FILTER |=> hrdata <= 32'h0000000f)
      else $error("ff filter over limit");
endmodule : slbf_sva
`default_nettype wire
